/* core/stop_seq_pkg.sv */
// constants, register map and state codes for the stop sequencer
package stop_seq_pkg;
    // time base
    localparam int CLK_PERIOD_NS  = 25;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_DELAY  = 8'h04;
    localparam logic [7:0] OFS_COMP   = 8'h08;
    localparam logic [7:0] OFS_STEP   = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // ctrl fields
    localparam int CTRL_SEL_LSB  = 0;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_VARIANT  = 8;

    // status fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_BRAKE     = 8;
    localparam int STAT_BASE      = 9;
    localparam int STAT_FAULT     = 10;
    localparam int STAT_DB        = 11;
    localparam int STAT_FFALL     = 12;

    // decel function select values
    localparam logic [1:0] SEL_DISABLED = 2'h0;
    localparam logic [1:0] SEL_ENABLED  = 2'h2;

    // reset values
    localparam logic [1:0]  RST_SEL   = 2'h0;
    localparam logic [15:0] RST_DELAY = 16'h0000;
    localparam logic [15:0] RST_COMP  = 16'h0000;
    localparam logic [15:0] RST_STEP  = 16'h0001;
    localparam logic [2:0]  RST_MODE  = 3'h0;

    // operation modes
    localparam logic [2:0] MODE_POSITION    = 3'h0;
    localparam logic [2:0] MODE_POINT_TABLE = 3'h1;
    localparam logic [2:0] MODE_HOMING      = 3'h2;
    localparam logic [2:0] MODE_JOG         = 3'h3;
    localparam logic [2:0] MODE_VELOCITY    = 3'h4;
    localparam logic [2:0] MODE_TORQUE      = 3'h5;
    localparam logic [2:0] MODE_CONT_TORQUE = 3'h6;

    typedef enum logic [4:0] {
        ST_OFF   = 5'h01,
        ST_RUN   = 5'h02,
        ST_DECEL = 5'h04,
        ST_DELAY = 5'h08,
        ST_DB    = 5'h10
    } seq_state_type;
endpackage : stop_seq_pkg

/* core/brake_delay_timer.sv */
// millisecond tick and brake-to-base down counter
`timescale 1ns/1ps
module brake_delay_timer #(
    parameter int TICK_CYCLES = stop_seq_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // control
    input  wire logic        load,
    input  wire logic [15:0] load_ms,
    // status
    output logic             tick,
    output logic             expired
);
    typedef struct packed {
        logic [31:0] prescale;
        logic [15:0] ms;
        logic        tick;
    } timer_type;

    timer_type r;
    timer_type next_r;

    always_comb begin
        next_r      = r;
        next_r.tick = 1'b0;
        if (load) begin
            // restart the prescaler so the delay is whole milliseconds
            next_r.prescale = 32'h0;
            next_r.ms       = load_ms;
        end else if (r.prescale == 32'(TICK_CYCLES - 1)) begin
            next_r.prescale = 32'h0;
            next_r.tick     = 1'b1;
            if (r.ms != 16'h0) begin
                next_r.ms = r.ms - 16'h1;
            end
        end else begin
            next_r.prescale = r.prescale + 32'h1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tick    = r.tick;
    assign expired = (r.ms == 16'h0);
endmodule : brake_delay_timer

/* core/servo_stop_brake_sequencer.sv */
// stop sequencer: forced-stop deceleration, brake interlock, base delay, dynamic brake
//
// Implementation choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module servo_stop_brake_sequencer #(
    parameter int TICK_CYCLES = stop_seq_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // controller commands and discrete stops
    input  wire logic        ready_on_cmd,
    input  wire logic        servo_enable_input,
    input  wire logic        quick_stop_cmd,
    input  wire logic        decel_stop_input,
    input  wire logic        hard_stop_input,
    // fault and power events
    input  wire logic        alarm_in,
    input  wire logic        alarm_excluded,
    input  wire logic        comm_loss,
    input  wire logic        comm_loss_db,
    input  wire logic        voltage_drop,
    input  wire logic        control_power_lost,
    // motor feedback
    input  wire logic [15:0] motor_speed,
    input  wire logic        zero_speed,
    // amplifier outputs
    output logic             brake_interlock_out,
    output logic             base_on,
    output logic             fault_output,
    output logic             dynamic_brake_on,
    output logic [15:0]      model_speed_cmd,
    output logic             freefall_active,
    output logic [15:0]      freefall_comp_amount
);
    typedef struct packed {
        stop_seq_pkg::seq_state_type state;
        logic [1:0]  decel_function_select;
        logic [2:0]  op_mode;
        logic        discrete_variant;
        logic [15:0] brake_sequence_delay_param;
        logic [15:0] freefall_comp_param;
        logic [15:0] decel_step;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [31:0] rdata;
        logic        ready;
        logic        load;
        logic        why_fault;
        logic        why_lift;
        logic        db_after;
        logic        brake;
        logic        base;
        logic        fault;
        logic        db;
        logic [15:0] model;
        logic        ffall;
        logic [15:0] lift;
    } core_regs_type;

    core_regs_type r;
    core_regs_type next_r;

    logic tick;
    logic expired;

    brake_delay_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .clk     (clk),
        .sys_rst (sys_rst),
        .load    (r.load),
        .load_ms (r.brake_sequence_delay_param),
        .tick    (tick),
        .expired (expired)
    );

    function automatic logic [31:0] read_reg(input core_regs_type s, input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0;
        unique case (a)
            stop_seq_pkg::OFS_CTRL: begin
                v[stop_seq_pkg::CTRL_SEL_LSB +: 2]  = s.decel_function_select;
                v[stop_seq_pkg::CTRL_MODE_LSB +: 3] = s.op_mode;
                v[stop_seq_pkg::CTRL_VARIANT]       = s.discrete_variant;
            end
            stop_seq_pkg::OFS_DELAY:  v[15:0] = s.brake_sequence_delay_param;
            stop_seq_pkg::OFS_COMP:   v[15:0] = s.freefall_comp_param;
            stop_seq_pkg::OFS_STEP:   v[15:0] = s.decel_step;
            stop_seq_pkg::OFS_STATUS: begin
                v[stop_seq_pkg::STAT_STATE_LSB +: 5] = s.state;
                v[stop_seq_pkg::STAT_BRAKE]          = s.brake;
                v[stop_seq_pkg::STAT_BASE]           = s.base;
                v[stop_seq_pkg::STAT_FAULT]          = s.fault;
                v[stop_seq_pkg::STAT_DB]             = s.db;
                v[stop_seq_pkg::STAT_FFALL]          = s.ffall;
            end
            default: v = 32'h0;
        endcase
        return v;
    endfunction : read_reg

    logic decel_ok;
    logic torque_mode;
    logic lift_mode;
    logic stop_req;
    logic need_db;

    always_comb begin
        // only value 2 enables; 0 and anything else leave it off
        decel_ok    = (r.decel_function_select == stop_seq_pkg::SEL_ENABLED);
        torque_mode = (r.op_mode == stop_seq_pkg::MODE_TORQUE) ||
                      (r.op_mode == stop_seq_pkg::MODE_CONT_TORQUE);
        lift_mode   = (r.op_mode == stop_seq_pkg::MODE_POSITION) ||
                      (r.op_mode == stop_seq_pkg::MODE_POINT_TABLE) ||
                      (r.op_mode == stop_seq_pkg::MODE_HOMING) ||
                      (r.op_mode == stop_seq_pkg::MODE_JOG);
        stop_req    = quick_stop_cmd || decel_stop_input || alarm_in || comm_loss || voltage_drop;
        need_db     = control_power_lost || hard_stop_input || (comm_loss && comm_loss_db) ||
                      (alarm_in && alarm_excluded) || (stop_req && (!decel_ok || torque_mode));
    end

    always_comb begin
        next_r       = r;
        next_r.load  = 1'b0;
        next_r.ready = 1'b1;

        // bus: one-cycle data phase, no wait states
        if (r.wr_pend) begin
            unique case (r.wr_addr)
                stop_seq_pkg::OFS_CTRL: begin
                    next_r.decel_function_select = hwdata[stop_seq_pkg::CTRL_SEL_LSB +: 2];
                    next_r.op_mode               = hwdata[stop_seq_pkg::CTRL_MODE_LSB +: 3];
                    next_r.discrete_variant      = hwdata[stop_seq_pkg::CTRL_VARIANT];
                end
                stop_seq_pkg::OFS_DELAY: next_r.brake_sequence_delay_param = hwdata[15:0];
                stop_seq_pkg::OFS_COMP:  next_r.freefall_comp_param        = hwdata[15:0];
                stop_seq_pkg::OFS_STEP:  next_r.decel_step                 = hwdata[15:0];
                default: next_r.wr_pend = 1'b0;
            endcase
        end
        next_r.wr_pend = hsel && hready && htrans[1] && hwrite;
        next_r.wr_addr = {haddr[7:2], 2'h0};
        if (hsel && hready && htrans[1] && !hwrite) begin
            next_r.rdata = read_reg(r, {haddr[7:2], 2'h0});
        end

        unique case (r.state)
            stop_seq_pkg::ST_OFF: begin
                next_r.base  = 1'b0;
                next_r.brake = 1'b0;
                next_r.db    = 1'b1;
                next_r.ffall = 1'b0;
                next_r.model = 16'h0;
                if (!alarm_in && !comm_loss) begin
                    next_r.fault = 1'b1;
                end
                if (ready_on_cmd && servo_enable_input && !stop_req && !hard_stop_input &&
                    !control_power_lost && !alarm_in && !comm_loss) begin
                    next_r.state = stop_seq_pkg::ST_RUN;
                    next_r.base  = 1'b1;
                    next_r.brake = 1'b1;
                    next_r.db    = 1'b0;
                end
            end
            stop_seq_pkg::ST_RUN: begin
                next_r.why_fault = alarm_in || comm_loss;
                next_r.why_lift  = decel_stop_input || (alarm_in && !alarm_excluded) || comm_loss;
                next_r.db_after  = voltage_drop;
                if (!ready_on_cmd || need_db) begin
                    // immediate base off, brakes take the motor
                    next_r.state = stop_seq_pkg::ST_DB;
                end else if (stop_req) begin
                    // servo-on already gone in the discrete variant: plain servo-off path
                    if (r.discrete_variant && !servo_enable_input && decel_stop_input) begin
                        next_r.state = stop_seq_pkg::ST_DELAY;
                        next_r.brake = 1'b0;
                        next_r.load  = 1'b1;
                    end else begin
                        next_r.state = stop_seq_pkg::ST_DECEL;
                        next_r.model = motor_speed;
                    end
                end else if (!servo_enable_input) begin
                    next_r.state = stop_seq_pkg::ST_DELAY;
                    next_r.brake = 1'b0;
                    next_r.load  = 1'b1;
                end
            end
            stop_seq_pkg::ST_DECEL: begin
                if (tick) begin
                    // model speed ramps independently of controller commands
                    next_r.model = (r.model > r.decel_step) ? r.model - r.decel_step : 16'h0;
                end
                if (!ready_on_cmd || control_power_lost || hard_stop_input) begin
                    next_r.state = stop_seq_pkg::ST_DB;
                end else if (r.model == 16'h0 && zero_speed) begin
                    next_r.state = stop_seq_pkg::ST_DELAY;
                    next_r.brake = 1'b0;
                    next_r.load  = 1'b1;
                end
            end
            stop_seq_pkg::ST_DELAY: begin
                // lift only when configured, enabled and in a position-type mode
                next_r.ffall = r.why_lift && zero_speed && decel_ok && lift_mode &&
                               r.freefall_comp_param != 16'h0 &&
                               r.brake_sequence_delay_param != 16'h0;
                if (!ready_on_cmd || control_power_lost) begin
                    next_r.state = stop_seq_pkg::ST_DB;
                end else if (!r.load && expired) begin
                    next_r.state = r.db_after ? stop_seq_pkg::ST_DB : stop_seq_pkg::ST_OFF;
                    next_r.base  = 1'b0;
                    next_r.ffall = 1'b0;
                    if (r.why_fault) begin
                        next_r.fault = 1'b0;
                    end
                end
            end
            stop_seq_pkg::ST_DB: begin
                next_r.base  = 1'b0;
                next_r.brake = 1'b0;
                next_r.db    = 1'b1;
                next_r.ffall = 1'b0;
                next_r.model = 16'h0;
                if (alarm_in || comm_loss) begin
                    next_r.fault = 1'b0;
                end
                next_r.state = stop_seq_pkg::ST_OFF;
            end
        endcase
        next_r.lift = next_r.ffall ? r.freefall_comp_param : 16'h0;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r                            <= '0;
            r.state                      <= stop_seq_pkg::ST_OFF;
            r.decel_function_select      <= stop_seq_pkg::RST_SEL;
            r.op_mode                    <= stop_seq_pkg::RST_MODE;
            r.brake_sequence_delay_param <= stop_seq_pkg::RST_DELAY;
            r.freefall_comp_param        <= stop_seq_pkg::RST_COMP;
            r.decel_step                 <= stop_seq_pkg::RST_STEP;
            r.ready                      <= 1'b1;
            r.fault                      <= 1'b1;
            r.db                         <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // the controller is trusted to withdraw stops before servo and ready
    assign hrdata               = r.rdata;
    assign hreadyout            = r.ready;
    assign hresp                = 1'b0;
    assign brake_interlock_out  = r.brake;
    assign base_on              = r.base;
    assign fault_output         = r.fault;
    assign dynamic_brake_on     = r.db;
    assign model_speed_cmd      = r.model;
    assign freefall_active      = r.ffall;
    assign freefall_comp_amount = r.lift;
endmodule : servo_stop_brake_sequencer

/* test/stop_seq_monitor.sv */
// port checker for the stop sequencer
`timescale 1ns/1ps
module stop_seq_monitor (
    // clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // bus answer
    input wire logic        hreadyout,
    input wire logic        hresp,
    // commands and stops
    input wire logic        ready_on_cmd,
    input wire logic        hard_stop_input,
    input wire logic        control_power_lost,
    // amplifier outputs
    input wire logic        brake_interlock_out,
    input wire logic        base_on,
    input wire logic        fault_output,
    input wire logic        dynamic_brake_on,
    input wire logic [15:0] model_speed_cmd,
    input wire logic        freefall_active,
    input wire logic [15:0] freefall_comp_amount
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // brake drop on the decelerating path happens with base still on
    sequence brake_drop_s;
        $fell(brake_interlock_out) && base_on;
    endsequence
    sequence db_entry_s;
        $rose(dynamic_brake_on);
    endsequence
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    brake_base_a: assert property (brake_interlock_out |-> base_on)
        else $error("brake released with base off");
    db_base_a: assert property (dynamic_brake_on |-> !base_on)
        else $error("dynamic brake with base on");
    fault_base_a: assert property (!fault_output |-> !base_on)
        else $error("fault output low with base on");
    ff_amount_a: assert property (!freefall_active |-> freefall_comp_amount == 16'h0000)
        else $error("lift amount shown while idle");
    ramp_down_a: assert property ((model_speed_cmd != 16'h0000 && $past(model_speed_cmd) != 16'h0000)
        |-> model_speed_cmd <= $past(model_speed_cmd)) else $error("model speed rose during ramp");
    rest_brake_a: assert property (brake_drop_s |-> model_speed_cmd == 16'h0000 && !dynamic_brake_on)
        else $error("brake dropped before standstill");
    db_brake_a: assert property (db_entry_s |-> !base_on && !brake_interlock_out)
        else $error("dynamic brake without both brakes");
    ready_off_a: assert property ($fell(ready_on_cmd) && base_on |-> ##[1:3] !base_on)
        else $error("base not off after ready off");
    hard_stop_a: assert property ($rose(hard_stop_input) && base_on |-> ##[1:3] dynamic_brake_on)
        else $error("hard stop without dynamic brake");
    power_loss_a: assert property ($rose(control_power_lost) && base_on
        |-> ##[1:3] (dynamic_brake_on && !brake_interlock_out)) else $error("power loss without brakes");
endmodule : stop_seq_monitor

bind servo_stop_brake_sequencer stop_seq_monitor mon (.clk(clk), .sys_rst(sys_rst), .hreadyout(hreadyout),
    .hresp(hresp), .ready_on_cmd(ready_on_cmd), .hard_stop_input(hard_stop_input),
    .control_power_lost(control_power_lost), .brake_interlock_out(brake_interlock_out), .base_on(base_on),
    .fault_output(fault_output), .dynamic_brake_on(dynamic_brake_on), .model_speed_cmd(model_speed_cmd),
    .freefall_active(freefall_active), .freefall_comp_amount(freefall_comp_amount));

/* test/ctrl_partner.sv */
// motion controller model: ready, servo and quick stop commands
`timescale 1ns/1ps
module ctrl_partner (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // requests from the bench
    input wire logic run_req,
    input wire logic stop_req,
    input wire logic ready_cut,
    // commands to the amplifier
    output logic     ready_on_cmd,
    output logic     servo_enable_input,
    output logic     quick_stop_cmd
);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ready_on_cmd <= 1'b0;
            servo_enable_input <= 1'b0;
            quick_stop_cmd <= 1'b0;
        end else begin
            quick_stop_cmd <= stop_req;
            if (ready_cut) begin
                // out of order on purpose, only when the bench asks
                ready_on_cmd <= 1'b0;
            end else if (run_req) begin
                ready_on_cmd <= 1'b1;
                servo_enable_input <= 1'b1;
            end else if (!stop_req && !quick_stop_cmd) begin
                servo_enable_input <= 1'b0;
                ready_on_cmd <= ready_on_cmd && servo_enable_input;
            end
        end
    end
endmodule : ctrl_partner

/* test/testbench.sv */
// self-checking bench for the stop sequencer
`timescale 1ns/1ps
module testbench;
    localparam int TK = 10;
    logic        clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, run_req = 1'b0, cut = 1'b0;
    logic        zero_speed = 1'b0, zs_pre = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [7:0]  haddr = 8'h00;
    logic [31:0] hwdata = 32'h0, r = 32'h076b, hrdata;
    logic [15:0] motor_speed = 16'h0, model_speed_cmd, freefall_comp_amount;
    logic [10:0] ev = 11'h0;
    logic        hready_w, hresp, ready_on_cmd, servo_enable_input, quick_stop_cmd;
    logic        brake_interlock_out, base_on, fault_output, dynamic_brake_on, freefall_active;
    int          n_mismatch = 0, checks = 0;

    always #12.5 clk = ~clk;
    // zero speed copies the ramp seen at the falling edge, so no race with the design's edge
    always @(negedge clk) zs_pre = (|ev) && model_speed_cmd == 16'h0000;
    always @(posedge clk) zero_speed <= zs_pre;

    ctrl_partner ctl (.clk(clk), .sys_rst(sys_rst), .run_req(run_req), .stop_req(ev[0] | ev[10]),
        .ready_cut(ev[9] | cut), .ready_on_cmd(ready_on_cmd), .servo_enable_input(servo_enable_input),
        .quick_stop_cmd(quick_stop_cmd));
    servo_stop_brake_sequencer #(.TICK_CYCLES(TK)) dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready_w),
        .hrdata(hrdata), .hreadyout(hready_w), .hresp(hresp), .ready_on_cmd(ready_on_cmd),
        .servo_enable_input(servo_enable_input), .quick_stop_cmd(quick_stop_cmd), .decel_stop_input(ev[1]),
        .hard_stop_input(ev[2]), .alarm_in(ev[3] | ev[4]), .alarm_excluded(ev[4]), .comm_loss(ev[5] | ev[6]),
        .comm_loss_db(ev[6]), .voltage_drop(ev[7]), .control_power_lost(ev[8]), .motor_speed(motor_speed),
        .zero_speed(zero_speed), .brake_interlock_out(brake_interlock_out), .base_on(base_on),
        .fault_output(fault_output), .dynamic_brake_on(dynamic_brake_on), .model_speed_cmd(model_speed_cmd),
        .freefall_active(freefall_active), .freefall_comp_amount(freefall_comp_amount));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk1

    // hready is only assumed high once sampled; a stuck slave is left to the watchdog
    task automatic wait_ready();
        @(posedge clk);
        while (hready_w !== 1'b1) begin
            @(posedge clk);
        end
    endtask : wait_ready

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : bus

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        bus(1'b0, a, 32'h0, rd);
        chk(rd, exp);
    endtask : rchk

    task automatic stop_case(input int c, input logic [1:0] sel, input logic [2:0] mode, input logic [31:0] s);
        logic [31:0] rd;
        logic [15:0] dly, comp;
        logic        dec_seen, ff_seen, db_seen, exp_dec, exp_ff, slow;
        int          t, tb, tbase, lo;
        dly = {14'h0, s[9:8]};
        comp = {8'h0, s[23:16]};
        lo = int'(dly) * TK;
        dec_seen = 1'b0;
        ff_seen = 1'b0;
        db_seen = 1'b0;
        tb = -1;
        tbase = 3000;
        exp_dec = sel == stop_seq_pkg::SEL_ENABLED && mode < 3'h5 && c inside {0, 1, 3, 5, 7, 10};
        exp_ff = exp_dec && mode < 3'h4 && comp != 16'h0 && dly != 16'h0 && c inside {1, 3, 5};
        slow = exp_dec && c != 10;
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        bus(1'b1, stop_seq_pkg::OFS_CTRL, {24'h0, 1'b0, mode, 2'h0, sel}, rd);
        bus(1'b1, stop_seq_pkg::OFS_DELAY, {16'h0, dly}, rd);
        bus(1'b1, stop_seq_pkg::OFS_COMP, {16'h0, comp}, rd);
        bus(1'b1, stop_seq_pkg::OFS_STEP, {29'h0, s[26:24]} + 32'h1, rd);
        run_req <= 1'b1;
        motor_speed <= {10'h0, s[5:0]} | 16'h0001;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk1(brake_interlock_out, 1'b1);
        @(posedge clk);
        ev <= 11'h1 << c;
        for (t = 0; t < tbase + 4; t++) begin
            @(negedge clk);
            dec_seen |= model_speed_cmd !== 16'h0;
            // the rest state engages the dynamic brake, so only count it up to base off
            db_seen |= dynamic_brake_on === 1'b1 && tbase == 3000;
            if (freefall_active === 1'b1 && !ff_seen) chk({16'h0, freefall_comp_amount}, {16'h0, comp});
            ff_seen |= freefall_active === 1'b1;
            if (tb < 0 && brake_interlock_out === 1'b0) tb = t;
            if (tbase == 3000 && base_on === 1'b0) tbase = t;
            @(posedge clk);
            cut <= c == 10 && dec_seen;
        end
        @(negedge clk);
        chk1(dec_seen, exp_dec);
        chk1(ff_seen, exp_ff);
        chk1(db_seen, !slow);
        chk1(dynamic_brake_on, 1'b1);
        chk1(fault_output, !(c inside {3, 4, 5, 6}));
        if (slow) begin
            chk1(tbase - tb >= lo && tbase - tb <= lo + TK + 3, 1'b1);
        end else begin
            chk1(tb >= 0 && tbase - tb <= 3, 1'b1);
        end
        @(posedge clk);
        ev <= 11'h0;
        cut <= 1'b0;
        run_req <= 1'b0;
        repeat (4) @(posedge clk);
        $display("stop case %0d sel %0d mode %0d done", c, sel, mode);
    endtask : stop_case

    initial begin
        logic [31:0] rd;
        int          i, c, g;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk1(brake_interlock_out, 1'b0);
        chk1(fault_output & dynamic_brake_on & !base_on & !freefall_active, 1'b1);
        @(posedge clk);
        for (i = 0; i < 6; i++) begin
            rchk(8'(4 * i), i == 3 ? 32'h1 : i == 4 ? 32'h0c01 : 32'h0);
        end
        bus(1'b1, stop_seq_pkg::OFS_DELAY, 32'hffff1234, rd);
        bus(1'b1, 8'h14, 32'h5a5a5a5a, rd);
        bus(1'b1, stop_seq_pkg::OFS_STATUS, 32'hffffffff, rd);
        rchk(stop_seq_pkg::OFS_DELAY, 32'h1234);
        rchk(8'h14, 32'h0);
        rchk(stop_seq_pkg::OFS_STATUS, 32'h0c01);
        $display("register test done");
        // every stop cause under position-type, mixed-select and velocity or torque settings
        for (c = 0; c < 11; c++) begin
            for (g = 0; g < 3; g++) begin
                r = lfsr_next(lfsr_next(r));
                stop_case(c, g == 1 ? 2'(c % 4) : stop_seq_pkg::SEL_ENABLED,
                    g == 0 ? 3'(r[1:0]) : g == 1 ? 3'(r[31:28] % 7) : 3'(4 + r[29:28] % 3), r);
            end
        end
        report_and_stop();
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule : testbench
